//--- design/lmcfg_top.sv
// Purpose: local memory configuration control register with power-on straps
// Assumes: strap pins from the board, register port on clk_sys
// Notes: straps sampled while reset is high; software write overrides them
`timescale 1ns/1ps
`include "lmcfg_cfg.svh"
module lmcfg_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Strap pins
  input wire lmcfg_pkg::lmcfg_straps_t straps,
  // Embedded memory select
  input wire logic embedded_sel,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`LMCFG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Decoded configuration
  output lmcfg_pkg::lmcfg_size_t mem_size,
  output logic [1:0] column_size,
  output logic bus_width_64,
  output lmcfg_pkg::lmcfg_decoded_t decoded
);

  // ---------------------------------------------
  // Strap synchronisers
  // ---------------------------------------------
  lmcfg_pkg::lmcfg_straps_t strap_meta;
  lmcfg_pkg::lmcfg_straps_t strap_sync;
  logic [31:0] ctrl;
  logic hit;
  logic [31:0] next_ctrl;

  always_ff @(posedge clk_sys) begin
    strap_meta <= straps;
    strap_sync <= strap_meta;
  end

  assign hit = (reg_addr == `LMCFG_CTRL_OFFSET);

  // ---------------------------------------------
  // Control register
  // ---------------------------------------------
  // Straps re-sampled every reset cycle, so last level before release wins
  always_comb begin
    next_ctrl = ctrl;
    if (rst) begin
      next_ctrl = `LMCFG_CTRL_RST;
      next_ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] = strap_sync.size_strap_pins;
      next_ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO] = strap_sync.column_strap_pins;
      next_ctrl[`LMCFG_WIDTH_BIT] = strap_sync.width_strap_pin;
    end else if (reg_wr && hit) begin
      next_ctrl = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    ctrl <= next_ctrl;
  end

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= (reg_rd && hit) ? ctrl : 32'h00000000;
    end
  end

  // ---------------------------------------------
  // Field outputs and decode
  // ---------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_size <= lmcfg_pkg::LMCFG_SIZE_16MB;
      column_size <= 2'h0;
      bus_width_64 <= 1'b0;
    end else begin
      mem_size <= lmcfg_pkg::lmcfg_size_t'(ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO]);
      column_size <= ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO];
      bus_width_64 <= ctrl[`LMCFG_WIDTH_BIT] & ~embedded_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      decoded <= '0;
    end else begin
      // Embedded memory is fixed: 16MB on a 32-bit path
      if (embedded_sel) begin
        decoded.size_mb <= `LMCFG_EMB_MB;
        decoded.bus_bits <= `LMCFG_BUS_32;
      end else begin
        case (ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO])
          2'h0: decoded.size_mb <= `LMCFG_MB_16;
          2'h1: decoded.size_mb <= `LMCFG_MB_32;
          2'h2: decoded.size_mb <= `LMCFG_MB_64;
          default: decoded.size_mb <= `LMCFG_MB_8;
        endcase
        decoded.bus_bits <= ctrl[`LMCFG_WIDTH_BIT] ? `LMCFG_BUS_64 : `LMCFG_BUS_32;
      end
      case (ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO])
        2'h0: decoded.column_words <= `LMCFG_COLS_256;
        2'h1: decoded.column_words <= `LMCFG_COLS_512;
        default: decoded.column_words <= `LMCFG_COLS_1024;
      endcase
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  property p_write_takes;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && hit) |=> (ctrl == $past(reg_wdata));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("write not stored");

  // Three reset edges first, so the synchroniser no longer holds unknowns
  property p_strap_size;
    @(posedge clk_sys)
    rst [*3] |=> ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] == $past(strap_sync.size_strap_pins);
  endproperty
  a_strap_size: assert property (p_strap_size) else $error("size strap lost");

  property p_strap_col;
    @(posedge clk_sys)
    rst [*3] |=> ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO] == $past(strap_sync.column_strap_pins);
  endproperty
  a_strap_col: assert property (p_strap_col) else $error("column strap lost");

  property p_strap_width;
    @(posedge clk_sys)
    rst [*3] |=> ctrl[`LMCFG_WIDTH_BIT] == $past(strap_sync.width_strap_pin);
  endproperty
  a_strap_width: assert property (p_strap_width) else $error("width strap lost");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    !(reg_wr && hit) |=> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed without write");

  property p_read;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && hit && !reg_wr) |=> reg_rvalid && reg_rdata == $past(ctrl);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_size_dec;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] == 2'h3) ##1 $stable(ctrl) |-> decoded.size_mb == `LMCFG_MB_8;
  endproperty
  a_size_dec: assert property (p_size_dec) else $error("size decode wrong");

  property p_col_dec;
    @(posedge clk_sys) disable iff (rst)
    ctrl[`LMCFG_COL_HI] ##1 $stable(ctrl) |-> decoded.column_words == `LMCFG_COLS_1024;
  endproperty
  a_col_dec: assert property (p_col_dec) else $error("column decode wrong");

  property p_width_dec;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && ctrl[`LMCFG_WIDTH_BIT]) ##1 $stable(ctrl) |-> decoded.bus_bits == `LMCFG_BUS_64;
  endproperty
  a_width_dec: assert property (p_width_dec) else $error("width decode wrong");

  property p_embedded;
    @(posedge clk_sys) disable iff (rst)
    embedded_sel |=> decoded.bus_bits == `LMCFG_BUS_32 && decoded.size_mb == `LMCFG_EMB_MB;
  endproperty
  a_embedded: assert property (p_embedded) else $error("embedded not 32-bit 16MB");

  // ---------------------------------------------
  // Register access checks
  // ---------------------------------------------
  property p_rvalid_pulse;
    @(posedge clk_sys) disable iff (rst)
    reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  property p_rvalid_idle;
    @(posedge clk_sys) disable iff (rst)
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");

  property p_miss_read;
    @(posedge clk_sys) disable iff (rst)
    (reg_rd && !hit) |=> reg_rdata == 32'h00000000;
  endproperty
  a_miss_read: assert property (p_miss_read) else $error("unmapped read not zero");

  property p_miss_write;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && !hit) |=> $stable(ctrl);
  endproperty
  a_miss_write: assert property (p_miss_write) else $error("unmapped write landed");

  // ---------------------------------------------
  // Field output checks
  // ---------------------------------------------
  property p_size_out;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> mem_size == lmcfg_pkg::lmcfg_size_t'($past(ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO]));
  endproperty
  a_size_out: assert property (p_size_out) else $error("size field output wrong");

  property p_col_out;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> column_size == $past(ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO]);
  endproperty
  a_col_out: assert property (p_col_out) else $error("column field output wrong");

  property p_width_out;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> bus_width_64 == $past(ctrl[`LMCFG_WIDTH_BIT] & ~embedded_sel);
  endproperty
  a_width_out: assert property (p_width_out) else $error("width output wrong");

  property p_emb_narrow;
    @(posedge clk_sys) disable iff (rst)
    embedded_sel |=> !bus_width_64;
  endproperty
  a_emb_narrow: assert property (p_emb_narrow) else $error("embedded memory on wide bus");

  // ---------------------------------------------
  // Decode checks
  // ---------------------------------------------
  property p_size_16;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] == 2'h0) ##1 $stable(ctrl) |-> decoded.size_mb == `LMCFG_MB_16;
  endproperty
  a_size_16: assert property (p_size_16) else $error("size code 0 decode wrong");

  property p_size_32;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] == 2'h1) ##1 $stable(ctrl) |-> decoded.size_mb == `LMCFG_MB_32;
  endproperty
  a_size_32: assert property (p_size_32) else $error("size code 1 decode wrong");

  property p_size_64;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && ctrl[`LMCFG_SIZE_HI:`LMCFG_SIZE_LO] == 2'h2) ##1 $stable(ctrl) |-> decoded.size_mb == `LMCFG_MB_64;
  endproperty
  a_size_64: assert property (p_size_64) else $error("size code 2 decode wrong");

  property p_col_256;
    @(posedge clk_sys) disable iff (rst)
    (ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO] == 2'h0) ##1 $stable(ctrl) |-> decoded.column_words == `LMCFG_COLS_256;
  endproperty
  a_col_256: assert property (p_col_256) else $error("column code 0 decode wrong");

  property p_col_512;
    @(posedge clk_sys) disable iff (rst)
    (ctrl[`LMCFG_COL_HI:`LMCFG_COL_LO] == 2'h1) ##1 $stable(ctrl) |-> decoded.column_words == `LMCFG_COLS_512;
  endproperty
  a_col_512: assert property (p_col_512) else $error("column code 1 decode wrong");

  property p_width_32;
    @(posedge clk_sys) disable iff (rst)
    (!embedded_sel && !ctrl[`LMCFG_WIDTH_BIT]) ##1 $stable(ctrl) |-> decoded.bus_bits == `LMCFG_BUS_32;
  endproperty
  a_width_32: assert property (p_width_32) else $error("narrow width decode wrong");

  // ---------------------------------------------
  // Reset checks
  // ---------------------------------------------
  // Outputs are quiet while reset holds, so no stale decode reaches users
  property p_reset_clear;
    @(posedge clk_sys)
    rst |=> !reg_rvalid && reg_rdata == 32'h00000000 && decoded == '0 && !bus_width_64;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared in reset");

  c_reload: cover property (@(posedge clk_sys) rst ##1 !rst);
  c_write: cover property (@(posedge clk_sys) disable iff (rst) reg_wr && hit);
  c_read: cover property (@(posedge clk_sys) disable iff (rst) reg_rd && hit);
  c_wide: cover property (@(posedge clk_sys) disable iff (rst) bus_width_64);
  c_emb: cover property (@(posedge clk_sys) disable iff (rst) embedded_sel);

endmodule // lmcfg_top

//--- shared/lmcfg_cfg.svh
// Purpose: constants for the local memory configuration block
// Assumes: 32-bit register window, word offsets as byte addresses
// Notes: included by the package and the design
`ifndef LMCFG_CFG_SVH
`define LMCFG_CFG_SVH
`define LMCFG_ADDR_W 24
`define LMCFG_CTRL_OFFSET 24'h000004
`define LMCFG_WIDTH_BIT 1
`define LMCFG_SIZE_LO 12
`define LMCFG_SIZE_HI 13
`define LMCFG_COL_LO 14
`define LMCFG_COL_HI 15
`define LMCFG_CTRL_RST 32'h00000000
`define LMCFG_MB_8 8'h08
`define LMCFG_MB_16 8'h10
`define LMCFG_MB_32 8'h20
`define LMCFG_MB_64 8'h40
`define LMCFG_COLS_256 11'h100
`define LMCFG_COLS_512 11'h200
`define LMCFG_COLS_1024 11'h400
`define LMCFG_EMB_MB 8'h10
`define LMCFG_EMB_MHZ 145
`define LMCFG_BUS_32 7'h20
`define LMCFG_BUS_64 7'h40
`endif

//--- shared/lmcfg_pkg.sv
// Purpose: types for the local memory configuration block
// Assumes: constants come from lmcfg_cfg.svh
// Notes: none
`include "lmcfg_cfg.svh"
package lmcfg_pkg;
  typedef enum logic [1:0] {
    LMCFG_SIZE_16MB,
    LMCFG_SIZE_32MB,
    LMCFG_SIZE_64MB,
    LMCFG_SIZE_8MB
  } lmcfg_size_t;

  typedef struct packed {
    logic [1:0] size_strap_pins;
    logic [1:0] column_strap_pins;
    logic width_strap_pin;
  } lmcfg_straps_t;

  typedef struct packed {
    logic [7:0] size_mb;
    logic [10:0] column_words;
    logic [6:0] bus_bits;
  } lmcfg_decoded_t;
endpackage

//--- tb/tb_top.sv
// Purpose: self-checking bench for the local memory configuration block
// Assumes: straps stable while rst high; register port driven on falling edges
// Notes: reset and strap checks first, then ordinary writes from a table; odd cases and a second reset follow
`timescale 1ns/1ps
`include "lmcfg_cfg.svh"
module tb_top;
  typedef struct packed {
    logic [31:0] wdata;
    logic emb;
    logic [1:0] size;
    logic [1:0] col;
    logic w64;
    logic [25:0] dec;
  } lmcfg_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  lmcfg_pkg::lmcfg_straps_t straps = 5'h13;
  logic embedded_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`LMCFG_ADDR_W-1:0] reg_addr = 24'h000000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  lmcfg_pkg::lmcfg_size_t mem_size;
  logic [1:0] column_size;
  logic bus_width_64;
  lmcfg_pkg::lmcfg_decoded_t decoded;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  lmcfg_row_t rows[5];
  lmcfg_row_t rs;

  lmcfg_top u_dut (.clk_sys(clk_sys), .rst(rst), .straps(straps), .embedded_sel(embedded_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mem_size(mem_size), .column_size(column_size), .bus_width_64(bus_width_64),
    .decoded(decoded));

  always #2 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Hang guard: whole run needs under a hundred cycles
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input lmcfg_row_t r);
    chk({30'h0, mem_size}, {30'h0, r.size});
    chk({30'h0, column_size}, {30'h0, r.col});
    chk({31'h0, bus_width_64}, {31'h0, r.w64});
    chk({6'h0, decoded}, {6'h0, r.dec});
  endtask

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Strobe held one cycle; answer looked at in its only valid cycle
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
    @(negedge clk_sys);
    chk({31'h0, reg_rvalid}, 32'h0);
  endtask

  task automatic do_reset(input logic [4:0] s, input logic e);
    @(negedge clk_sys);
    rst = 1'b1;
    straps = s;
    embedded_sel = e;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{32'h00000000, 1'b0, 2'h0, 2'h0, 1'b0, {`LMCFG_MB_16, `LMCFG_COLS_256, `LMCFG_BUS_32}};
    rows[1] = '{32'h00005002, 1'b0, 2'h1, 2'h1, 1'b1, {`LMCFG_MB_32, `LMCFG_COLS_512, `LMCFG_BUS_64}};
    rows[2] = '{32'h0000A000, 1'b0, 2'h2, 2'h2, 1'b0, {`LMCFG_MB_64, `LMCFG_COLS_1024, `LMCFG_BUS_32}};
    rows[3] = '{32'h0000F002, 1'b0, 2'h3, 2'h3, 1'b1, {`LMCFG_MB_8, `LMCFG_COLS_1024, `LMCFG_BUS_64}};
    rows[4] = '{32'hFFFFFFFF, 1'b1, 2'h3, 2'h3, 1'b0, {`LMCFG_EMB_MB, `LMCFG_COLS_1024, `LMCFG_BUS_32}};
    do_reset(5'h13, 1'b0);
    rs = '{32'h00006002, 1'b0, 2'h2, 2'h1, 1'b1, {`LMCFG_MB_64, `LMCFG_COLS_512, `LMCFG_BUS_64}};
    chk_cfg(rs);
    rd(24'h000004, rs.wdata);
    straps = 5'h0C;
    repeat (4) @(negedge clk_sys);
    chk_cfg(rs);
    foreach (rows[i]) begin
      embedded_sel = rows[i].emb;
      wr(24'h000004, rows[i].wdata);
      @(negedge clk_sys);
      chk_cfg(rows[i]);
      rd(24'h000004, rows[i].wdata);
    end
    // Unmapped offset: write ignored, read gives zero
    wr(24'h000008, 32'h00000000);
    @(negedge clk_sys);
    chk_cfg(rows[4]);
    rd(24'h000008, 32'h00000000);
    embedded_sel = 1'b0;
    // Back-to-back writes: strobe held, last value wins
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = 24'h000004;
    reg_wdata = rows[2].wdata;
    @(negedge clk_sys);
    reg_wdata = rows[1].wdata;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
    chk_cfg(rows[1]);
    // Second reset: new straps reloaded over the written value
    do_reset(5'h1F, 1'b1);
    rs = '{32'h0000F002, 1'b1, 2'h3, 2'h3, 1'b0, {`LMCFG_EMB_MB, `LMCFG_COLS_1024, `LMCFG_BUS_32}};
    chk_cfg(rs);
    rd(24'h000004, rs.wdata);
    wrap_up();
  end
endmodule // tb_top
